// [hdl/cisd_pkg.sv]
// Purpose: constants and types of the charger indicator and setting decode
// Assumes: 10 MHz clock, resistor values in 100 ohm units, thermistor in mV
// Notes:   the base tick of 50 ms paces every flash pattern
package cisd_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_MS       = 50;
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned TICKS_PER_S   = 1000 / TICK_MS;
  localparam int unsigned SLOW_MS       = 1000;
  localparam int unsigned FAST_MS       = 250;
  localparam int unsigned EMPTY_MS      = 200;
  localparam int unsigned EMPTY_FLASHES = 4;
  localparam logic [5:0]  SLOW_TICKS    = 6'(SLOW_MS / TICK_MS);
  localparam logic [5:0]  FAST_TICKS    = 6'(FAST_MS / TICK_MS);
  localparam logic [5:0]  EMPTY_TICKS   = 6'(EMPTY_MS / TICK_MS);
  localparam logic [5:0]  EMPTY_TOTAL   = 6'(2 * EMPTY_FLASHES * EMPTY_MS
                                             / TICK_MS);
  localparam logic [5:0]  PAT_LAST      = 6'(2 * SLOW_MS / TICK_MS - 1);
  // setting resistor, 100 ohm units
  localparam int unsigned RES_SAT   = 250;
  localparam int unsigned RES_OPEN  = 330;
  localparam int unsigned RES_100W  = 225;
  localparam int unsigned RES_60W   = 125;
  localparam int unsigned RES_45W   = 100;
  localparam int unsigned RES_30W   = 70;
  localparam int unsigned RES_25W   = 58;
  localparam int unsigned PWR_NUM   = 4;
  localparam int unsigned PWR_DEN   = 10;
  localparam int unsigned CUR_DIV   = 5;
  localparam logic [6:0]  PWR_MAX_W = 7'h64;
  localparam logic [5:0]  CUR_MAX   = 6'h32;
  localparam logic [6:0]  ADV_100W  = 7'h64;
  localparam logic [6:0]  ADV_60W   = 7'h3C;
  localparam logic [6:0]  ADV_45W   = 7'h2D;
  localparam logic [6:0]  ADV_30W   = 7'h1E;
  localparam logic [6:0]  ADV_25W   = 7'h19;
  localparam logic [6:0]  ADV_20W   = 7'h14;
  // capacity: 0.8 mAh per ohm is 80 mAh per unit
  localparam int unsigned CAP_PER_UNIT = 80;
  localparam int unsigned CAP_MIN_MAH  = 2000;
  localparam int unsigned CAP_MAX_MAH  = 25000;
  localparam int unsigned SEC_PER_H    = 3600;
  // thermistor window, mV
  localparam logic [11:0] CHG_COLD_MV = 12'h226;
  localparam logic [11:0] CHG_HOT_MV  = 12'h186;
  localparam logic [11:0] DIS_COLD_MV = 12'h56E;
  localparam logic [11:0] DIS_HOT_MV  = 12'h0F0;
  localparam logic [11:0] BIAS_SW_MV  = 12'h320;
  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CHARGE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LIMITS = 8'h0C;
  localparam logic [7:0] REG_CAP    = 8'h10;
  typedef enum logic [1:0] {ARR_FOUR, ARR_TWO_BAR, ARR_TWO_STATE,
                            ARR_ONE} cisd_arr_t;
  localparam cisd_arr_t CTRL_RESET = ARR_FOUR;
  typedef enum logic [2:0] {DSP_IDLE, DSP_CHG, DSP_FULL, DSP_ABN,
                            DSP_DIS, DSP_EMPTY, DSP_HALT} cisd_disp_t;
  typedef struct packed {
    logic [6:0] input_power_w;
    logic [5:0] current_steps;
    logic [6:0] adv_power_w;
    logic       pdo_20v_5a;
  } cisd_limits_t;
  typedef struct packed {
    logic power_reduce;
    logic discharge_allow;
    logic charge_allow;
    logic empty_halt;
    logic bias_high;
    logic dis_hot;
    logic dis_cold;
    logic chg_hot;
    logic chg_cold;
    logic setting_open;
    logic abnormal;
  } cisd_status_t;
endpackage

// [hdl/cisd_top.sv]
// Purpose: setting decode, thermistor windows, fuel gauge and LED display
// Assumes: analog values arrive digitised on this clock; mode pin is async
// Notes:   every output is a flip-flop; ce_in low freezes all state
module cisd_top #(
  parameter int unsigned TICK_CYCLES = cisd_pkg::TICK_CYCLES,
  parameter int unsigned RES_W       = 9,
  parameter bit          ADAPTIVE    = 1'b1
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  // register port
  input  wire logic [7:0]             addr_in,
  input  wire logic [31:0]            wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic [31:0]                 rdata_out,
  // settings
  input  wire logic [RES_W-1:0]       power_setting_resistor_in,
  input  wire logic [RES_W-1:0]       capacity_resistor_in,
  input  wire logic                   setting_mode_pin_in,
  input  wire logic [6:0]             supply_power_w_in,
  input  wire logic                   emark_cable_in,
  // battery state
  input  wire logic                   charging_in,
  input  wire logic                   discharging_in,
  input  wire logic                   charge_full_in,
  input  wire logic                   charge_fault_in,
  input  wire logic signed [15:0]     cell_current_ma_in,
  input  wire logic [11:0]            thermistor_mv_in,
  // results
  output cisd_pkg::cisd_limits_t      limits_out,
  output logic                        power_reduce_out,
  output logic                        thermistor_bias_high_out,
  output logic                        charge_allow_out,
  output logic                        discharge_allow_out,
  output logic                        abnormal_out,
  // indicators
  output logic                        led_first_out,
  output logic                        led_second_out,
  output logic                        led_third_out,
  output logic                        led_fourth_out
);
  import cisd_pkg::*;

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int ACC_W  = 27;

  if (TICK_CYCLES < 1 || RES_W < 9 || RES_W > 16)
  begin : g_bad_param
    $error("cisd_top: unsupported parameter values");
  end

  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick_reg;
  logic [4:0]        sec_cnt_reg;
  logic              mode_meta_reg;
  logic              mode_sync_reg;
  cisd_arr_t         arr_reg;
  logic [6:0]        set_power_reg;
  cisd_limits_t      limits_next;
  logic              setting_open_reg;
  logic [14:0]       cap_reg;
  logic [ACC_W-1:0]  full_reg;
  logic [ACC_W-1:0]  acc_reg;
  cisd_status_t      status;
  logic              chg_cold_reg;
  logic              chg_hot_reg;
  logic              dis_cold_reg;
  logic              dis_hot_reg;
  logic              empty_halt_reg;
  logic [1:0]        q4;
  logic [1:0]        t3;
  logic              empty;
  cisd_disp_t        disp;
  logic [9:0]        disp_code;
  logic [9:0]        disp_reg;
  logic [5:0]        pat_cnt_reg;
  logic              slow_on;
  logic              fast_on;
  logic              empty_on;
  logic [3:0]        four_chg;
  logic [3:0]        four_dis;
  logic [3:0]        led_next;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // base tick shared by every pattern and the gauge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
      sec_cnt_reg  <= '0;
    end
    else if (ce_in)
    begin
      tick_reg <= (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
      if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1))
        tick_cnt_reg <= '0;
      else
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
      if (tick_reg)
        sec_cnt_reg <= (sec_cnt_reg == 5'(TICKS_PER_S - 1)) ?
                       '0 : sec_cnt_reg + 1'b1;
    end
  end

  // mode pin comes from a strap, so it is synchronised
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      mode_meta_reg <= setting_mode_pin_in;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // setting and capacity decode
  always_comb
  begin
    int unsigned res;
    int unsigned calc;
    res  = int'(power_setting_resistor_in);
    calc = 0;
    limits_next = '0;
    if (res >= RES_SAT)
    begin
      limits_next.current_steps = CUR_MAX;
    end
    else
    begin
      calc = res / CUR_DIV;
      limits_next.current_steps = 6'(calc);
    end
    // non-adaptive variant keeps the full setting
    if (ADAPTIVE && mode_sync_reg && supply_power_w_in < set_power_reg)
      limits_next.input_power_w = supply_power_w_in;
    else
      limits_next.input_power_w = set_power_reg;
    if (res >= RES_100W)
      limits_next.adv_power_w = ADV_100W;
    else if (res >= RES_60W)
      limits_next.adv_power_w = ADV_60W;
    else if (res >= RES_45W)
      limits_next.adv_power_w = ADV_45W;
    else if (res >= RES_30W)
      limits_next.adv_power_w = ADV_30W;
    else if (res >= RES_25W)
      limits_next.adv_power_w = ADV_25W;
    else
      limits_next.adv_power_w = ADV_20W;
    if (limits_next.adv_power_w > ADV_60W)
    begin
      if (!emark_cable_in)
        limits_next.adv_power_w = ADV_60W;
      limits_next.pdo_20v_5a = emark_cable_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      set_power_reg    <= '0;
      setting_open_reg <= 1'b0;
      limits_out       <= '0;
      power_reduce_out <= 1'b0;
      cap_reg          <= '0;
      full_reg         <= '0;
    end
    else if (ce_in)
    begin
      if (int'(power_setting_resistor_in) >= RES_SAT)
        set_power_reg <= PWR_MAX_W;
      else
        set_power_reg <= 7'(int'(power_setting_resistor_in) * PWR_NUM
                            / PWR_DEN);
      setting_open_reg <= int'(power_setting_resistor_in) > RES_OPEN;
      limits_out       <= limits_next;
      power_reduce_out <= ADAPTIVE && mode_sync_reg &&
                          supply_power_w_in < set_power_reg;
      if (int'(capacity_resistor_in) * CAP_PER_UNIT < CAP_MIN_MAH)
        cap_reg <= 15'(CAP_MIN_MAH);
      else if (int'(capacity_resistor_in) * CAP_PER_UNIT > CAP_MAX_MAH)
        cap_reg <= 15'(CAP_MAX_MAH);
      else
        cap_reg <= 15'(int'(capacity_resistor_in) * CAP_PER_UNIT);
      full_reg <= ACC_W'(int'(cap_reg) * SEC_PER_H);
    end
  end

  // thermistor windows and permissions
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chg_cold_reg             <= 1'b0;
      chg_hot_reg              <= 1'b0;
      dis_cold_reg             <= 1'b0;
      dis_hot_reg              <= 1'b0;
      thermistor_bias_high_out <= 1'b0;
      abnormal_out             <= 1'b0;
      charge_allow_out         <= 1'b0;
      discharge_allow_out      <= 1'b0;
    end
    else if (ce_in)
    begin
      chg_cold_reg <= thermistor_mv_in > CHG_COLD_MV;
      chg_hot_reg  <= thermistor_mv_in < CHG_HOT_MV;
      dis_cold_reg <= thermistor_mv_in > DIS_COLD_MV;
      dis_hot_reg  <= thermistor_mv_in < DIS_HOT_MV;
      // low voltage means hot, where the stronger bias resolves better
      thermistor_bias_high_out <= thermistor_mv_in < BIAS_SW_MV;
      abnormal_out <= setting_open_reg | charge_fault_in;
      charge_allow_out <= charging_in && !chg_cold_reg && !chg_hot_reg &&
                          !abnormal_out;
      discharge_allow_out <= discharging_in && !dis_cold_reg &&
                             !dis_hot_reg && !empty_halt_reg;
    end
  end

  // fuel gauge in mA*s, clamped to the full-cell charge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      acc_reg <= '0;
    else if (ce_in)
    begin
      if (wr_in && addr_in == REG_CHARGE)
        acc_reg <= (wdata_in[ACC_W-1:0] > full_reg) ?
                   full_reg : wdata_in[ACC_W-1:0];
      else if (tick_reg && sec_cnt_reg == 5'(TICKS_PER_S - 1))
      begin
        if (!cell_current_ma_in[15])
          acc_reg <= (acc_reg + ACC_W'(cell_current_ma_in) > full_reg) ?
                     full_reg : acc_reg + ACC_W'(cell_current_ma_in);
        else if (acc_reg < ACC_W'(-cell_current_ma_in))
          acc_reg <= '0;
        else
          acc_reg <= acc_reg - ACC_W'(-cell_current_ma_in);
      end
    end
  end

  // charge bands: quarters and thirds
  always_comb
  begin
    logic [31:0] a4;
    logic [31:0] a3;
    logic [31:0] f;
    a4 = 32'(acc_reg) << 2;
    a3 = 32'(acc_reg) * 32'h3;
    f  = 32'(full_reg);
    empty = (acc_reg == '0);
    if (a4 >= f * 32'h3)
      q4 = 2'h3;
    else if (a4 >= f * 32'h2)
      q4 = 2'h2;
    else if (a4 >= f)
      q4 = 2'h1;
    else
      q4 = 2'h0;
    if (a3 >= f * 32'h2)
      t3 = 2'h2;
    else if (a3 >= f)
      t3 = 2'h1;
    else
      t3 = 2'h0;
  end

  // display state
  always_comb
  begin
    if (charging_in)
    begin
      if (abnormal_out)
        disp = DSP_ABN;
      else if (charge_full_in)
        disp = DSP_FULL;
      else
        disp = DSP_CHG;
    end
    else if (discharging_in)
    begin
      if (empty_halt_reg)
        disp = DSP_HALT;
      else if (empty)
        disp = DSP_EMPTY;
      else
        disp = DSP_DIS;
    end
    else
      disp = DSP_IDLE;
  end

  assign disp_code = {disp, arr_reg, q4, t3, 1'b0};

  // one pattern counter; any change of display restarts it from lit
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      disp_reg       <= '0;
      pat_cnt_reg    <= '0;
      empty_halt_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      disp_reg <= disp_code;
      if (disp_code != disp_reg)
        pat_cnt_reg <= '0;
      else if (tick_reg)
      begin
        if (disp == DSP_EMPTY)
          pat_cnt_reg <= (pat_cnt_reg == EMPTY_TOTAL) ?
                         pat_cnt_reg : pat_cnt_reg + 1'b1;
        else
          pat_cnt_reg <= (pat_cnt_reg == PAT_LAST) ?
                         '0 : pat_cnt_reg + 1'b1;
      end
      if (disp == DSP_EMPTY && pat_cnt_reg == EMPTY_TOTAL &&
          disp_code == disp_reg)
        empty_halt_reg <= 1'b1;
      else if (!discharging_in || !empty)
        empty_halt_reg <= 1'b0;
    end
  end

  assign slow_on  = pat_cnt_reg < SLOW_TICKS;
  assign fast_on  = (pat_cnt_reg % (FAST_TICKS << 1)) < FAST_TICKS;
  assign empty_on = pat_cnt_reg < EMPTY_TOTAL &&
                    (pat_cnt_reg % (EMPTY_TICKS << 1)) < EMPTY_TICKS;

  for (genvar i = 0; i < 4; i++)
  begin : g_bar
    assign four_chg[i] = (2'(i) < q4) ? 1'b1 :
                         (2'(i) == q4) ? slow_on : 1'b0;
    assign four_dis[i] = 2'(i) <= q4;
  end

  always_comb
  begin
    led_next = 4'h0;
    case (disp)
      DSP_CHG:
        case (arr_reg)
          ARR_FOUR:      led_next = four_chg;
          ARR_TWO_BAR:   led_next = {2'b00, t3 != 2'h0 ? slow_on : 1'b0,
                                     t3 != 2'h2 ? slow_on : 1'b0};
          ARR_TWO_STATE: led_next = 4'h1;
          default:       led_next = {3'b000, slow_on};
        endcase
      DSP_FULL:
        case (arr_reg)
          ARR_FOUR:      led_next = 4'hF;
          ARR_ONE:       led_next = 4'h1;
          default:       led_next = 4'h2;
        endcase
      DSP_ABN:
        if (arr_reg == ARR_TWO_STATE)
          led_next = {2'b00, fast_on, fast_on};
        else
          led_next = {3'b000, fast_on};
      DSP_DIS:
        case (arr_reg)
          ARR_FOUR:      led_next = four_dis;
          ARR_TWO_BAR:   led_next = {2'b00, t3 != 2'h0,
                                     t3 != 2'h2};
          default:       led_next = 4'h1;
        endcase
      DSP_EMPTY:         led_next = {3'b000, empty_on};
      default:           led_next = 4'h0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      led_first_out  <= 1'b0;
      led_second_out <= 1'b0;
      led_third_out  <= 1'b0;
      led_fourth_out <= 1'b0;
    end
    else if (ce_in)
    begin
      led_first_out  <= led_next[0];
      led_second_out <= led_next[1];
      led_third_out  <= led_next[2];
      led_fourth_out <= led_next[3];
    end
  end

  // register port; read data stand for one cycle only
  assign status = '{power_reduce: power_reduce_out,
                    discharge_allow: discharge_allow_out,
                    charge_allow: charge_allow_out,
                    empty_halt: empty_halt_reg,
                    bias_high: thermistor_bias_high_out,
                    dis_hot: dis_hot_reg, dis_cold: dis_cold_reg,
                    chg_hot: chg_hot_reg, chg_cold: chg_cold_reg,
                    setting_open: setting_open_reg,
                    abnormal: abnormal_out};

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      arr_reg   <= CTRL_RESET;
      rdata_out <= '0;
    end
    else if (ce_in)
    begin
      if (wr_in && addr_in == REG_CTRL)
        arr_reg <= cisd_arr_t'(wdata_in[1:0]);
      rdata_out <= '0;
      if (rd_in)
      begin
        if (addr_in == REG_CTRL)
          rdata_out <= {30'h0, arr_reg};
        else if (addr_in == REG_CHARGE)
          rdata_out <= 32'(acc_reg);
        else if (addr_in == REG_STATUS)
          rdata_out <= 32'(status);
        else if (addr_in == REG_LIMITS)
          rdata_out <= 32'(limits_out);
        else if (addr_in == REG_CAP)
          rdata_out <= 32'(cap_reg);
      end
    end
  end

  property p_open;
    ce_in && int'(power_setting_resistor_in) > RES_OPEN ##1 ce_in
      |=> abnormal_out;
  endproperty
  a_open: assert property (p_open)
    else $error("open setting resistor not flagged");

  property p_chg_cold;
    ce_in && charging_in && chg_cold_reg |=> !charge_allow_out;
  endproperty
  a_chg_cold: assert property (p_chg_cold)
    else $error("charge allowed while too cold");

  property p_dis_window;
    ce_in && (dis_hot_reg || dis_cold_reg) |=> !discharge_allow_out;
  endproperty
  a_dis_window: assert property (p_dis_window)
    else $error("discharge allowed outside window");

  property p_bias;
    ce_in |=> thermistor_bias_high_out == ($past(thermistor_mv_in)
                                           < BIAS_SW_MV);
  endproperty
  a_bias: assert property (p_bias)
    else $error("thermistor bias wrong");

  property p_sat;
    ce_in && int'(power_setting_resistor_in) >= RES_SAT
      |=> set_power_reg == PWR_MAX_W && limits_out.current_steps == CUR_MAX;
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturated setting not at maximum");

  property p_nomark;
    ce_in && !emark_cable_in |=> limits_out.adv_power_w <= ADV_60W &&
                                 !limits_out.pdo_20v_5a;
  endproperty
  a_nomark: assert property (p_nomark)
    else $error("over 60W advertised without marked cable");

  property p_full4;
    ce_in && disp == DSP_FULL && arr_reg == ARR_FOUR
      |=> led_first_out && led_second_out && led_third_out &&
          led_fourth_out;
  endproperty
  a_full4: assert property (p_full4)
    else $error("four LEDs not all lit at full");

  property p_halt;
    ce_in && empty_halt_reg && discharging_in && !charging_in
      |=> !discharge_allow_out && !led_first_out;
  endproperty
  a_halt: assert property (p_halt)
    else $error("discharge continues after empty flashes");

  property p_restart;
    ce_in && disp_code != disp_reg |=> pat_cnt_reg == 6'h00;
  endproperty
  a_restart: assert property (p_restart)
    else $error("pattern not restarted on change");

  c_halt: cover property (ce_in && !empty_halt_reg ##1 empty_halt_reg);
  c_abn:  cover property (disp == DSP_ABN && arr_reg == ARR_TWO_STATE);
  c_band: cover property (disp == DSP_CHG && arr_reg == ARR_FOUR &&
                          q4 == 2'h2);
  c_red:  cover property (power_reduce_out);

endmodule // cisd_top

// [tb/cisd_far_model.sv]
// Purpose: thermistor seen from the device pin
// Assumes: resistance in ohm, bias current picked by the device
// Notes:   no hysteresis, so pick resistances away from the bias edge
module cisd_far_model (
  // device side
  input  wire logic        bias_high_in,
  input  wire logic [31:0] ntc_ohm_in,
  // pin voltage
  output logic [11:0]      thermistor_mv_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb
  begin
    thermistor_mv_out = 12'(ntc_ohm_in * (bias_high_in ? 80 : 20)
                            / 1000);
  end
endmodule // cisd_far_model

// [tb/cisd_test.sv]
// Purpose: self-checking bench of the setting decode and indicators
// Assumes: short tick of 4 cycles, ce_in held high
// Notes:   random resistor values from a fixed seed
module cisd_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cisd_pkg::*;
  logic               clk_in = 0, rst_in = 1, wr = 0, rd = 0, mode = 1;
  logic               emk = 1, chg = 0, dis = 0, full = 0, flt = 0;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wd = 32'h0, rdat, q, ohm = 32'h2710;
  logic [8:0]         res = 9'h096, cap = 9'h064;
  logic [6:0]         sup = 7'h64;
  logic signed [15:0] cur = 16'sh0000;
  logic [11:0]        mv;
  cisd_limits_t       lim;
  logic               pr, bh, ca, da, ab, l1, l2, l3, l4;
  int                 error_cnt = 0, checked = 0, cyc = 0, seed, ons;
  int                 tbl[13] = '{0, 50, 58, 70, 100, 125, 150, 224,
                                  225, 249, 250, 251, 329};
  always #50 clk_in = ~clk_in;
  cisd_top #(.TICK_CYCLES(4)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(1'b1), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdat), .power_setting_resistor_in(res),
    .capacity_resistor_in(cap), .setting_mode_pin_in(mode),
    .supply_power_w_in(sup), .emark_cable_in(emk), .charging_in(chg),
    .discharging_in(dis), .charge_full_in(full), .charge_fault_in(flt),
    .cell_current_ma_in(cur), .thermistor_mv_in(mv), .limits_out(lim),
    .power_reduce_out(pr), .thermistor_bias_high_out(bh),
    .charge_allow_out(ca), .discharge_allow_out(da), .abnormal_out(ab),
    .led_first_out(l1), .led_second_out(l2), .led_third_out(l3),
    .led_fourth_out(l4));
  cisd_far_model far (.bias_high_in(bh), .ntc_ohm_in(ohm),
    .thermistor_mv_out(mv));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic settle;
    repeat (10) @(posedge clk_in);
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 q = rdat;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk_in);
    wr   <= 1'b0;
  endtask
  function automatic int e_pw(int u);
    return u >= 250 ? 100 : u * 4 / 10;
  endfunction
  function automatic int e_adv(int u);
    return u >= 225 ? 100 : u >= 125 ? 60 : u >= 100 ? 45 :
           u >= 70 ? 30 : u >= 58 ? 25 : 20;
  endfunction
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  initial
  begin
    seed = 32'hb613baa1;
    repeat (10) @(posedge clk_in);
    chk({lim, l1, l2, l3, l4}, 32'h0);
    rst_in <= 1'b0;
    rd_reg(8'h14); chk(q, 32'h0);
    rd_reg(REG_CTRL); chk(q, 32'h0);
    for (int i = 0; i < 19; i++)
    begin
      res  <= 9'(i < 13 ? tbl[i] : {$random(seed)} % 330);
      mode <= 1'b1;
      settle;
      chk(lim.input_power_w, e_pw(res));
      chk(lim.adv_power_w, e_adv(res));
      chk(lim.pdo_20v_5a, res >= 225);
      mode <= 1'b0;
      emk  <= 1'b0;
      settle;
      chk(lim.current_steps, res >= 250 ? 50 : res / 5);
      chk(lim.adv_power_w, e_adv(res) > 60 ? 60 : e_adv(res));
      chk(lim.pdo_20v_5a, 1'b0);
      emk  <= 1'b1;
    end
    res <= 9'h190;
    settle;
    rd_reg(REG_STATUS); chk(q[1], 1'b1);
    chk(ab, 1'b1);
    res <= 9'h096; mode <= 1'b1; sup <= 7'h1E;
    settle;
    chk(pr, 1'b1);
    chk(lim.input_power_w, 7'h1E);
    sup <= 7'h64;
    foreach (tbl[i])
    begin
      cap <= 9'(i * 40);
      settle;
      rd_reg(REG_CAP);
      chk(q, (i * 3200 < 2000) ? 2000 :
             (i * 3200 > 25000) ? 25000 : i * 3200);
    end
    chg <= 1'b1;
    ohm <= 32'd7500; settle; chk({bh, ca}, 2'b10);
    ohm <= 32'd5625; settle; chk({bh, ca}, 2'b11);
    ohm <= 32'd3750; settle; chk(ca, 1'b0);
    chg <= 1'b0; dis <= 1'b1; wr_reg(REG_CHARGE, 32'h7FFFFFF);
    ohm <= 32'd75000; settle; chk({bh, da}, 2'b00);
    ohm <= 32'd50000; settle; chk({bh, da}, 2'b01);
    wr_reg(REG_CHARGE, 32'd5000); cur <= 16'sd1000;
    repeat (20) settle;
    rd_reg(REG_CHARGE); chk(q inside {32'd7000, 32'd8000}, 1'b1);
    cur <= -16'sd30000;
    repeat (24) settle; chk({da, l1}, 2'b00);
    rd_reg(REG_STATUS); chk(q[7], 1'b1);
    rd_reg(REG_CHARGE); chk(q, 32'h0);
    ohm <= 32'd2500; settle; chk(da, 1'b0);
    ohm <= 32'd5625; dis <= 1'b0; chg <= 1'b1;
    wr_reg(REG_CTRL, 32'h2);
    settle; chk({l1, l2}, 2'b10);
    full <= 1'b1; settle; chk({l1, l2}, 2'b01);
    full <= 1'b0; flt <= 1'b1; settle;
    ons = 0;
    repeat (60)
    begin
      @(posedge clk_in);
      #1 chk(l1, l2);
      ons += l1;
    end
    chk(ons inside {[1:59]}, 1'b1);
    wr_reg(REG_CTRL, 32'h3); flt <= 1'b0; full <= 1'b1;
    settle;
    repeat (60)
    begin
      @(posedge clk_in);
      #1 chk(l1, 1'b1);
    end
    full <= 1'b0; settle; chk(l1, 1'b1);
    repeat (8) settle; chk(l1, 1'b0);
    flt <= 1'b1; settle; chk(l1, 1'b1);
    repeat (2) settle; chk(l1, 1'b0);
    flt <= 1'b0; wr_reg(REG_CTRL, 32'h0);
    settle; chk({l1, l2, l3, l4}, 4'b1000);
    wr_reg(REG_CTRL, 32'h1);
    settle; chk({l1, l2}, 2'b10);
    wrap_up;
  end
endmodule // cisd_test
